// file: pkg/dpmc_defines.svh
// Constants for the duplex processor match checker: offsets, fields, reset values.
`ifndef DPMC_DEFINES_SVH
`define DPMC_DEFINES_SVH

// Data path and register bus widths.
`define DPMC_W 24
`define DPMC_AW 5

// Register indices on the plain register port.
`define DPMC_REG_STATUS 5'h00
`define DPMC_REG_MODE 5'h01
`define DPMC_REG_MASK0 5'h02
`define DPMC_REG_MASK1 5'h03
`define DPMC_REG_IRQ_MASK 5'h04
`define DPMC_REG_ACT_RBUF 5'h05
`define DPMC_REG_SBY_RBUF 5'h06
`define DPMC_REG_FAIL_ADDR 5'h07
`define DPMC_REG_INT_PADDR 5'h08
`define DPMC_REG_WORD_BASE 5'h09
`define DPMC_REG_WORD_LAST 5'h10

// Status field positions.
`define DPMC_TYPE_LSB 0
`define DPMC_TYPE_MSB 5
`define DPMC_MM_LSB 10
`define DPMC_MM_MSB 13
`define DPMC_RD_MM_BIT 14

// Reset values.
`define DPMC_MASK_RESET 24'hffffff
`define DPMC_ZERO 24'h000000
`define DPMC_MODE_RESET 2'h0

`endif

// file: pkg/dpmc_pkg.sv
// Types shared by the duplex processor match checker.
package dpmc_pkg;
    // Internal points a matcher may gate in.
    typedef enum logic [2:0]
    {
        DPMC_PT_PROG = 3'h0,
        DPMC_PT_DATA = 3'h1,
        DPMC_PT_BUF = 3'h2,
        DPMC_PT_MEMB = 3'h3,
        DPMC_PT_SEQ = 3'h4,
        DPMC_PT_UNIT = 3'h5
    } dpmc_point_t;
    // Cycle phases at which a point is sampled.
    typedef enum logic [1:0]
    {
        DPMC_PH_4T8 = 2'h0,
        DPMC_PH_0T4 = 2'h1,
        DPMC_PH_8T0 = 2'h2
    } dpmc_phase_t;
    // Selection made for one matcher.
    typedef struct packed
    {
        logic valid;
        dpmc_point_t point;
        dpmc_phase_t phase;
    } dpmc_sel_t;
endpackage

// file: hdl/dpmc_match_checker.sv
// Routine matching logic between the active and standby central processors.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "dpmc_defines.svh"
module dpmc_match_checker
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [`DPMC_AW-1:0] reg_addr,
    input wire logic [`DPMC_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DPMC_W-1:0] reg_rdata,
    input wire logic [5:0] instr_type,
    input wire logic phase_4t8,
    input wire logic phase_0t4,
    input wire logic phase_8t0,
    input wire logic [`DPMC_W-1:0] act_program_address_point,
    input wire logic [`DPMC_W-1:0] act_data_address_point,
    input wire logic [`DPMC_W-1:0] act_buffer_point,
    input wire logic [`DPMC_W-1:0] act_memory_bus_point,
    input wire logic [`DPMC_W-1:0] act_sequence_point,
    input wire logic [`DPMC_W-1:0] act_unit_bus_point,
    input wire logic [`DPMC_W-1:0] sby_program_address_point,
    input wire logic [`DPMC_W-1:0] sby_data_address_point,
    input wire logic [`DPMC_W-1:0] sby_buffer_point,
    input wire logic [`DPMC_W-1:0] sby_memory_bus_point,
    input wire logic [`DPMC_W-1:0] sby_sequence_point,
    input wire logic [`DPMC_W-1:0] sby_unit_bus_point,
    input wire logic mem_read_done,
    input wire logic [`DPMC_W-1:0] act_read_data,
    input wire logic [`DPMC_W-1:0] sby_read_data,
    input wire logic [`DPMC_W-1:0] mem_read_address,
    input wire logic [`DPMC_W-1:0] current_program_address,
    output logic match_irq,
    output logic standby_freeze
);
    import dpmc_pkg::*;

    // Software visible state.
    logic [1:0] match_mode_select; // Bit 0 runs active matchers, bit 1 standby ones.
    logic [`DPMC_W-1:0] compare_mask_zero; // Compare mask for both matchers 0.
    logic [`DPMC_W-1:0] compare_mask_one; // Compare mask for both matchers 1.
    logic [`DPMC_W-1:0] irq_mask; // Same layout as the status register.
    logic [`DPMC_W-1:0] match_status; // Sticky flags and instruction type.
    logic [`DPMC_W-1:0] active_read_buffer; // Active word of a disagreeing read.
    logic [`DPMC_W-1:0] standby_read_buffer; // Standby word of a disagreeing read.
    logic [`DPMC_W-1:0] failing_read_address; // Address of a disagreeing read.
    logic [`DPMC_W-1:0] interrupted_program_address; // Program address at the fault.
    logic [`DPMC_W-1:0] int_word [0:3]; // Last internal word gated to each matcher.
    logic [`DPMC_W-1:0] ext_word [0:3]; // Last external word gated to each matcher.

    // Point vectors of both processors, indexed by the point code.
    logic [`DPMC_W-1:0] act_pt [0:5];
    logic [`DPMC_W-1:0] sby_pt [0:5];
    logic [2:0] phase_vec; // Indexed by the phase code.
    logic [3:0] mm_event; // One mismatch pulse per matcher.
    logic rd_event; // Memory read disagreement in this cycle.
    logic [`DPMC_W-1:0] set_bits; // Flags that hardware sets this cycle.
    logic [`DPMC_W-1:0] clr_bits; // Flags that software clears this cycle.
    logic [`DPMC_W-1:0] next_status; // Status value after this edge.
    logic pending; // Some mismatch flag already held.
    logic first_fault; // A fault arrives while nothing is pending.
    logic wr_status; // Write aimed at the status register.
    logic irq_next; // An unmasked flag is set; the type field never interrupts.

    assign act_pt[0] = act_program_address_point;
    assign act_pt[1] = act_data_address_point;
    assign act_pt[2] = act_buffer_point;
    assign act_pt[3] = act_memory_bus_point;
    assign act_pt[4] = act_sequence_point;
    assign act_pt[5] = act_unit_bus_point;
    assign sby_pt[0] = sby_program_address_point;
    assign sby_pt[1] = sby_data_address_point;
    assign sby_pt[2] = sby_buffer_point;
    assign sby_pt[3] = sby_memory_bus_point;
    assign sby_pt[4] = sby_sequence_point;
    assign sby_pt[5] = sby_unit_bus_point;
    assign phase_vec = {phase_8t0, phase_0t4, phase_4t8};

    // Build one selection; a type code that is not one-hot selects nothing.
    function automatic dpmc_sel_t mk(input dpmc_point_t p, input dpmc_phase_t ph);
        dpmc_sel_t s;
        s.valid = 1'b1;
        s.point = p;
        s.phase = ph;
        return s;
    endfunction

    // Point and phase for matcher k (0 act m0, 1 sby m0, 2 act m1, 3 sby m1).
    // Standby matchers take the active table unless both processors match.
    function automatic dpmc_sel_t pick(input int k, input logic both, input logic [5:0] t);
        dpmc_sel_t s;
        logic sby_tab;
        s = '0;
        sby_tab = both && ((k == 1) || (k == 3));
        if (!sby_tab && (k < 2))
        begin
            unique case (t)
                6'h01: s = mk(DPMC_PT_PROG, DPMC_PH_4T8);
                6'h02: s = mk(DPMC_PT_DATA, DPMC_PH_8T0);
                6'h04: s = mk(DPMC_PT_DATA, DPMC_PH_8T0);
                6'h08: s = mk(DPMC_PT_DATA, DPMC_PH_8T0);
                6'h10: s = mk(DPMC_PT_PROG, DPMC_PH_4T8);
                6'h20: s = mk(DPMC_PT_SEQ, DPMC_PH_8T0);
                default: s = '0;
            endcase
        end
        else if (!sby_tab)
        begin
            unique case (t)
                6'h01: s = mk(DPMC_PT_BUF, DPMC_PH_0T4);
                6'h02: s = mk(DPMC_PT_MEMB, DPMC_PH_0T4);
                6'h04: s = mk(DPMC_PT_BUF, DPMC_PH_0T4);
                6'h08: s = mk(DPMC_PT_MEMB, DPMC_PH_8T0);
                6'h10: s = mk(DPMC_PT_BUF, DPMC_PH_0T4);
                6'h20: s = mk(DPMC_PT_BUF, DPMC_PH_0T4);
                default: s = '0;
            endcase
        end
        else if (k == 1)
        begin
            unique case (t)
                6'h01: s = mk(DPMC_PT_SEQ, DPMC_PH_8T0);
                6'h02: s = mk(DPMC_PT_MEMB, DPMC_PH_4T8);
                6'h04: s = mk(DPMC_PT_MEMB, DPMC_PH_4T8);
                6'h08: s = mk(DPMC_PT_MEMB, DPMC_PH_4T8);
                6'h10: s = mk(DPMC_PT_SEQ, DPMC_PH_8T0);
                6'h20: s = mk(DPMC_PT_DATA, DPMC_PH_8T0);
                default: s = '0;
            endcase
        end
        else
        begin
            unique case (t)
                6'h01: s = mk(DPMC_PT_MEMB, DPMC_PH_4T8);
                6'h02: s = mk(DPMC_PT_MEMB, DPMC_PH_8T0);
                6'h04: s = mk(DPMC_PT_MEMB, DPMC_PH_8T0);
                6'h08: s = mk(DPMC_PT_UNIT, DPMC_PH_4T8);
                6'h10: s = mk(DPMC_PT_DATA, DPMC_PH_8T0);
                6'h20: s = mk(DPMC_PT_MEMB, DPMC_PH_8T0);
                default: s = '0;
            endcase
        end
        return s;
    endfunction

    // The four matchers. Even ones sit in the active processor, odd ones in the
    // standby processor; matcher k reports on status bit 10 + k.
    genvar k;
    generate
        for (k = 0; k < 4; k++)
        begin : g_matcher
            dpmc_sel_t sel; // Point and phase chosen for this matcher.
            logic run; // Mode lets this matcher run.
            logic fire; // Selected phase strobe is present.
            logic [`DPMC_W-1:0] own_w; // Internal word of the matcher's processor.
            logic [`DPMC_W-1:0] far_w; // External word from the partner.
            logic [`DPMC_W-1:0] msk; // Mask register for this matcher number.
            assign sel = pick(k, &match_mode_select, instr_type);
            assign run = (k % 2 == 0) ? match_mode_select[0] : match_mode_select[1];
            assign fire = run && sel.valid && phase_vec[sel.phase];
            // Active matchers compare active internal against standby external,
            // standby matchers the mirror of that.
            assign own_w = (k % 2 == 0) ? act_pt[sel.point] : sby_pt[sel.point];
            assign far_w = (k % 2 == 0) ? sby_pt[sel.point] : act_pt[sel.point];
            assign msk = (k < 2) ? compare_mask_zero : compare_mask_one;
            // Only mask bits holding one can disagree.
            assign mm_event[k] = fire && (|((own_w ^ far_w) & msk));

            // Keep the gated words so software can see what was compared.
            always_ff @(posedge clk_sys)
            begin
                if (srst)
                begin
                    int_word[k] <= `DPMC_ZERO;
                    ext_word[k] <= `DPMC_ZERO;
                end
                else if (fire)
                begin
                    int_word[k] <= own_w;
                    ext_word[k] <= far_w;
                end
            end
        end
    endgenerate

    assign rd_event = mem_read_done && (act_read_data != sby_read_data);
    assign wr_status = reg_wr && (reg_addr == `DPMC_REG_STATUS);
    assign pending = |match_status[`DPMC_RD_MM_BIT:`DPMC_MM_LSB];
    assign first_fault = !pending && ((|mm_event) || rd_event);
    assign irq_next = |(next_status[`DPMC_RD_MM_BIT:`DPMC_MM_LSB]
        & irq_mask[`DPMC_RD_MM_BIT:`DPMC_MM_LSB]);

    // Status next value. A set in the same cycle as its clear wins.
    always_comb
    begin
        set_bits = `DPMC_ZERO;
        set_bits[`DPMC_MM_MSB:`DPMC_MM_LSB] = mm_event;
        set_bits[`DPMC_RD_MM_BIT] = rd_event;
        clr_bits = `DPMC_ZERO;
        if (wr_status)
        begin
            clr_bits[`DPMC_RD_MM_BIT:`DPMC_MM_LSB] = reg_wdata[`DPMC_RD_MM_BIT:`DPMC_MM_LSB];
        end
        next_status = (match_status & ~clr_bits) | set_bits;
        // The type field follows the first fault and is then held.
        if (first_fault)
        begin
            next_status[`DPMC_TYPE_MSB:`DPMC_TYPE_LSB] = instr_type;
        end
    end

    // Status register; with no mismatch the flag field stays all zero.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            match_status <= `DPMC_ZERO;
        end
        else
        begin
            match_status <= next_status;
        end
    end

    // Interrupt and standby freeze. The freeze stands as long as the interrupt,
    // so for an unmasked flag the standby state cannot move on before software clears it.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            match_irq <= 1'b0;
            standby_freeze <= 1'b0;
        end
        else
        begin
            match_irq <= irq_next;
            standby_freeze <= irq_next;
        end
    end

    // Memory read disagreement capture; kept only while no mismatch flag is already held.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            active_read_buffer <= `DPMC_ZERO;
            standby_read_buffer <= `DPMC_ZERO;
            failing_read_address <= `DPMC_ZERO;
        end
        else if (rd_event && !pending)
        begin
            active_read_buffer <= act_read_data;
            standby_read_buffer <= sby_read_data;
            failing_read_address <= mem_read_address;
        end
    end

    // Program address at the fault. It may already point past the failing one.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            interrupted_program_address <= `DPMC_ZERO;
        end
        else if (first_fault)
        begin
            interrupted_program_address <= current_program_address;
        end
    end

    // Control registers. Compare masks reset to all ones, the value routine matching needs.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            match_mode_select <= `DPMC_MODE_RESET;
            compare_mask_zero <= `DPMC_MASK_RESET;
            compare_mask_one <= `DPMC_MASK_RESET;
            irq_mask <= `DPMC_ZERO;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `DPMC_REG_MODE: match_mode_select <= reg_wdata[1:0];
                `DPMC_REG_MASK0: compare_mask_zero <= reg_wdata;
                `DPMC_REG_MASK1: compare_mask_one <= reg_wdata;
                `DPMC_REG_IRQ_MASK: irq_mask <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read port: data stand in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            reg_rdata <= `DPMC_ZERO;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `DPMC_REG_STATUS: reg_rdata <= match_status;
                `DPMC_REG_MODE: reg_rdata <= {22'h000000, match_mode_select};
                `DPMC_REG_MASK0: reg_rdata <= compare_mask_zero;
                `DPMC_REG_MASK1: reg_rdata <= compare_mask_one;
                `DPMC_REG_IRQ_MASK: reg_rdata <= irq_mask;
                `DPMC_REG_ACT_RBUF: reg_rdata <= active_read_buffer;
                `DPMC_REG_SBY_RBUF: reg_rdata <= standby_read_buffer;
                `DPMC_REG_FAIL_ADDR: reg_rdata <= failing_read_address;
                `DPMC_REG_INT_PADDR: reg_rdata <= interrupted_program_address;
                default:
                begin
                    if (reg_addr >= `DPMC_REG_WORD_BASE && reg_addr <= `DPMC_REG_WORD_LAST)
                    begin
                        reg_rdata <= reg_addr[0] ? int_word[2'((reg_addr - `DPMC_REG_WORD_BASE) >> 1)]
                                                 : ext_word[2'((reg_addr - `DPMC_REG_WORD_BASE) >> 1)];
                    end
                    else
                    begin
                        reg_rdata <= `DPMC_ZERO;
                    end
                end
            endcase
        end
    end

    // Checks kept beside the logic.
    active_bit_set_a: assert property (@(posedge clk_sys) disable iff (srst)
        mm_event[0] |=> match_status[10])
        else $error("Active matcher 0 mismatch did not set bit 10.");
    standby_bit_set_a: assert property (@(posedge clk_sys) disable iff (srst)
        mm_event[3] |=> match_status[13])
        else $error("Standby matcher 1 mismatch did not set bit 13.");
    mode_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
        (match_mode_select == 2'h1) |-> (mm_event[1] == 1'b0 && mm_event[3] == 1'b0))
        else $error("Standby matcher ran in active only mode.");
    mask_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
        (compare_mask_zero == `DPMC_ZERO) |-> !mm_event[0] && !mm_event[1])
        else $error("Matcher 0 reported with an all zero mask.");
    sticky_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        (match_status[11] && !wr_status) |=> match_status[11])
        else $error("Mismatch flag dropped without a clear.");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 (match_irq == |(match_status[`DPMC_RD_MM_BIT:`DPMC_MM_LSB]
            & $past(irq_mask[`DPMC_RD_MM_BIT:`DPMC_MM_LSB]))))
        else $error("Interrupt output disagrees with masked status.");
    freeze_irq_a: assert property (@(posedge clk_sys) disable iff (srst)
        standby_freeze == match_irq)
        else $error("Standby freeze does not follow the interrupt.");
    read_capture_a: assert property (@(posedge clk_sys) disable iff (srst)
        (rd_event && !pending) |=> (active_read_buffer == $past(act_read_data))
            && (failing_read_address == $past(mem_read_address)) && match_status[14])
        else $error("Read disagreement not captured.");
    type_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        (pending && !wr_status) |=> $stable(match_status[5:0]))
        else $error("Instruction type changed while a fault was pending.");
endmodule

// file: tb/dpmc_twin_model.sv
// Behavioural model of the twin processor that runs in step with the active one.
`timescale 1ns/100ps
`include "dpmc_defines.svh"
module dpmc_twin_model
(
    input wire logic [`DPMC_W*6-1:0] act_points,
    input wire logic [2:0] bad_point,
    input wire logic [`DPMC_W-1:0] bad_flip,
    input wire logic [`DPMC_W-1:0] act_read_data,
    input wire logic read_flip,
    output logic [`DPMC_W*6-1:0] sby_points,
    output logic [`DPMC_W-1:0] sby_read_data
);
    // A healthy twin shows the same word at every point; the bench may spoil one point.
    // Index 7 names no point, so it is how the bench keeps the twins in agreement.
    always_comb
    begin
        sby_points = act_points;
        for (int i = 0; i < 6; i++)
        begin
            // Only the chosen point differs, so only matchers gating it can complain.
            if (bad_point == 3'(i))
            begin
                sby_points[i*`DPMC_W +: `DPMC_W] = act_points[i*`DPMC_W +: `DPMC_W] ^ bad_flip;
            end
        end
    end
    // The twin's read word disagrees only when the bench asks for it.
    assign sby_read_data = read_flip ? (act_read_data ^ bad_flip) : act_read_data;
endmodule

// file: tb/duplex_processor_match_checker_tb.sv
// Self-checking bench for the duplex processor match checker.
`timescale 1ns/100ps
`include "dpmc_defines.svh"
module duplex_processor_match_checker_tb;
    import dpmc_pkg::*;
    // Point and phase pairs that the matchers may select.
    localparam logic [4:0] PA = {DPMC_PT_PROG, DPMC_PH_4T8};
    localparam logic [4:0] DA = {DPMC_PT_DATA, DPMC_PH_8T0};
    localparam logic [4:0] BB = {DPMC_PT_BUF, DPMC_PH_0T4};
    localparam logic [4:0] ME = {DPMC_PT_MEMB, DPMC_PH_0T4};
    localparam logic [4:0] MD = {DPMC_PT_MEMB, DPMC_PH_8T0};
    localparam logic [4:0] MA = {DPMC_PT_MEMB, DPMC_PH_4T8};
    localparam logic [4:0] SQ = {DPMC_PT_SEQ, DPMC_PH_8T0};
    localparam logic [4:0] UA = {DPMC_PT_UNIT, DPMC_PH_4T8};
    // Selections by instruction type: single-side table and both-side standby table.
    logic [4:0] sel_a0 [6] = '{PA, DA, DA, DA, PA, SQ};
    logic [4:0] sel_a1 [6] = '{BB, ME, BB, MD, BB, BB};
    logic [4:0] sel_b0 [6] = '{SQ, MA, MA, MA, SQ, DA};
    logic [4:0] sel_b1 [6] = '{MA, MD, MD, UA, DA, MD};
    // Design inputs, all given a value at time zero.
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [`DPMC_AW-1:0] reg_addr = '0;
    logic [`DPMC_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] instr_type = 6'h01;
    logic [2:0] phase = 3'h0;
    logic [`DPMC_W*6-1:0] act_pts = '0;
    logic mem_read_done = 1'b0;
    logic [`DPMC_W-1:0] act_rd = '0;
    logic [`DPMC_W-1:0] rd_addr = '0;
    logic [`DPMC_W-1:0] pc = '0;
    // Partner controls and design outputs.
    logic [2:0] bad_point = 3'h7;
    logic [`DPMC_W-1:0] bad_flip = '0;
    logic read_flip = 1'b0;
    logic [`DPMC_W*6-1:0] sby_pts;
    logic [`DPMC_W-1:0] sby_rd;
    logic [`DPMC_W-1:0] reg_rdata;
    logic match_irq;
    logic standby_freeze;
    // Bookkeeping.
    int n_errors = 0;
    int num_checks = 0;

    // The clock toggles every half period of 12.5 ns, a 25 ns period.
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    dpmc_match_checker dut
    (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_type(instr_type),
        .phase_4t8(phase[0]), .phase_0t4(phase[1]), .phase_8t0(phase[2]),
        .act_program_address_point(act_pts[23:0]), .act_data_address_point(act_pts[47:24]),
        .act_buffer_point(act_pts[71:48]), .act_memory_bus_point(act_pts[95:72]),
        .act_sequence_point(act_pts[119:96]), .act_unit_bus_point(act_pts[143:120]),
        .sby_program_address_point(sby_pts[23:0]), .sby_data_address_point(sby_pts[47:24]),
        .sby_buffer_point(sby_pts[71:48]), .sby_memory_bus_point(sby_pts[95:72]),
        .sby_sequence_point(sby_pts[119:96]), .sby_unit_bus_point(sby_pts[143:120]),
        .mem_read_done(mem_read_done), .act_read_data(act_rd), .sby_read_data(sby_rd),
        .mem_read_address(rd_addr), .current_program_address(pc),
        .match_irq(match_irq), .standby_freeze(standby_freeze)
    );

    dpmc_twin_model twin
    (
        .act_points(act_pts), .bad_point(bad_point), .bad_flip(bad_flip),
        .act_read_data(act_rd), .read_flip(read_flip), .sby_points(sby_pts),
        .sby_read_data(sby_rd)
    );

    // Selection of matcher k: bit 0 picks the standby side, bit 1 picks matcher 1.
    function automatic logic [4:0] sel_of(input int k, input int ty, input logic [1:0] md);
        if (k[0] && md == 2'h3)
            return k[1] ? sel_b1[ty] : sel_b0[ty];
        return k[1] ? sel_a1[ty] : sel_a0[ty];
    endfunction

    // Status bits 13..10 expected when point and phase hit are spoiled by flip.
    function automatic logic [3:0] exp_bits(input logic [1:0] md, input int ty,
        input logic [4:0] hit, input logic [23:0] flip, input logic [23:0] m0,
        input logic [23:0] m1);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < 4; k++)
        begin
            // A matcher runs only in its mode, and masked bits never disagree.
            if (md[k%2] && sel_of(k, ty, md) == hit && ((k > 1 ? m1 : m0) & flip) != 0)
                r[k] = 1'b1;
        end
        return r;
    endfunction

    // One register write: a single cycle with the write strobe high.
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // One register read; the data are valid from the cycle after the strobe until the next read.
    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // Reads a register and compares it.
    task automatic chk_rd(input logic [4:0] a, input logic [23:0] exp, input string m);
        logic [23:0] d;
        rd(a, d);
        chk(d, exp, m);
    endtask

    // Presents one matcher phase with fresh points, one of them spoiled in the twin.
    task automatic fire(input int ty, input logic [4:0] hit, input logic [23:0] flip);
        @(posedge clk_sys);
        instr_type <= 6'(1 << ty);
        pc <= 24'($urandom);
        act_pts <= 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
        bad_point <= hit[4:2];
        bad_flip <= flip;
        phase[hit[1:0]] <= 1'b1;
        @(posedge clk_sys);
        phase <= 3'h0;
        bad_point <= 3'h7;
    endtask

    // One memory read completion, with or without a disagreement between the twins.
    task automatic mem_read(input logic flip);
        @(posedge clk_sys);
        mem_read_done <= 1'b1;
        act_rd <= 24'($urandom);
        rd_addr <= 24'($urandom);
        bad_flip <= 24'h000100;
        read_flip <= flip;
        @(posedge clk_sys);
        mem_read_done <= 1'b0;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog: the tests need under a thousand cycles, so this limit means a hang.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end

    // Main sequence.
    initial
    begin
        logic [23:0] d;
        logic [23:0] m0;
        logic [23:0] m1;
        logic [4:0] hit;
        logic [23:0] flip;
        logic [3:0] e;
        void'($urandom(7473));
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        // Reset values, and an unmapped index that must read zero.
        chk_rd(`DPMC_REG_STATUS, 24'h000000, "status after reset");
        chk_rd(`DPMC_REG_MODE, 24'h000000, "mode after reset");
        chk_rd(`DPMC_REG_MASK0, 24'hffffff, "mask zero after reset");
        chk_rd(`DPMC_REG_MASK1, 24'hffffff, "mask one after reset");
        chk_rd(`DPMC_REG_IRQ_MASK, 24'h000000, "irq mask after reset");
        chk_rd(5'h1f, 24'h000000, "unmapped read");
        $display("Test reset values done");
        // Masked interrupt: the flag is kept but the line stays low until unmasked.
        wr(`DPMC_REG_MODE, 24'h000001);
        fire(0, PA, 24'h000001);
        chk_rd(`DPMC_REG_STATUS, 24'h000401, "masked flag");
        chk_rd(`DPMC_REG_WORD_BASE + 5'h01, act_pts[23:0] ^ 24'h1, "far word");
        chk({23'h0, match_irq}, 24'h000000, "irq while masked");
        wr(`DPMC_REG_IRQ_MASK, 24'h007c00);
        chk_rd(`DPMC_REG_STATUS, 24'h000401, "flag still held");
        chk({22'h0, match_irq, standby_freeze}, 24'h000003, "irq and freeze");
        wr(`DPMC_REG_STATUS, 24'h007c00);
        chk_rd(`DPMC_REG_STATUS, 24'h000001, "flag cleared");
        chk({22'h0, match_irq, standby_freeze}, 24'h000000, "irq dropped");
        $display("Test interrupt masking done");
        // Every mode, instruction type and matcher; random masks outside mode 01,
        // mask zero empty in mode 10 so its matcher must stay silent.
        for (int md = 0; md < 4; md++)
        begin
            m0 = (md == 1) ? 24'hffffff : (md == 2) ? 24'h0 : 24'($urandom);
            m1 = (md == 1) ? 24'hffffff : 24'($urandom);
            wr(`DPMC_REG_MASK0, m0);
            wr(`DPMC_REG_MASK1, m1);
            wr(`DPMC_REG_MODE, 24'(md));
            chk_rd(`DPMC_REG_MODE, 24'(md), "mode readback");
            for (int ty = 0; ty < 6; ty++)
            begin
                for (int k = 0; k < 4; k++)
                begin
                    hit = sel_of(k, ty, 2'(md));
                    flip = 24'h000001 << ($urandom % 24);
                    fire(ty, hit, flip);
                    e = exp_bits(2'(md), ty, hit, flip, m0, m1);
                    rd(`DPMC_REG_STATUS, d);
                    chk({19'h0, d[14:10]}, {20'h0, e}, "mismatch flags");
                    chk({23'h0, match_irq}, {23'h0, |e}, "irq level");
                    chk({23'h0, standby_freeze}, {23'h0, |e}, "freeze");
                    if (e != 4'h0)
                    begin
                        chk({18'h0, d[5:0]}, 24'(1 << ty), "type code");
                        chk_rd(`DPMC_REG_INT_PADDR, pc, "program address");
                    end
                    wr(`DPMC_REG_STATUS, 24'h007c00);
                end
            end
        end
        $display("Test matcher table done");
        // Memory reads: an agreeing read leaves no flag, a disagreeing one captures.
        mem_read(1'b0);
        rd(`DPMC_REG_STATUS, d);
        chk({23'h0, d[14]}, 24'h000000, "agreeing read");
        mem_read(1'b1);
        rd(`DPMC_REG_STATUS, d);
        chk({23'h0, d[14]}, 24'h000001, "read disagreement flag");
        chk_rd(`DPMC_REG_ACT_RBUF, act_rd, "active read word");
        chk_rd(`DPMC_REG_SBY_RBUF, act_rd ^ 24'h000100, "standby read word");
        chk_rd(`DPMC_REG_FAIL_ADDR, rd_addr, "failing address");
        $display("Test memory read compare done");
        finish_test();
    end
endmodule
